/* logic/pdmc_top.sv */
// Purpose: Low-power mode and clock control with subclock prescaler
// Assumes: 100 MHz mclk_i, subclock and wake sources arrive asynchronously
// Notes:
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "pdmc_defines.svh"

module pdmc_top
    import pdmc_pkg::*;
#(
    parameter bit VARIANT_TWO = 1'b0
) (
    // Clock, reset, enable
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Pins and sources
    input wire logic subclock_osc_in_i,
    input wire logic [15:0] irq_req_i,
    input wire logic condition_code_i_mask_i,
    input wire logic sleep_req_i,
    input wire logic standby_req_i,
    input wire logic watch_req_i,
    input wire logic ext_clock_i,
    // Outputs
    output logic cpu_run_o,
    output logic cpu_reset_o,
    output logic exception_start_o,
    output logic medium_speed_o,
    output logic sys_clk_en_o,
    output logic timer_a_tick_o,
    output logic [4:0] subclock_prescaler_o,
    output logic [7:0] module_run_o,
    output logic [15:0] irq_pend_o,
    output logic wait_code_bad_o
);

    logic [7:0] module_clock_stop_2_r;
    logic [7:0] timer_a_mode_register_r;
    logic [7:0] system_control_1_r;
    logic [15:0] irq_en_r;
    logic [4:0] subclock_prescaler_r;
    logic [2:0] sub_sync_r;
    logic sub_lvl_r;
    logic [1:0] sub_div_r;
    logic [15:0] irq_s1_r;
    logic [15:0] irq_s2_r;
    logic [17:0] wait_cnt_r;
    logic [2:0] div_cnt_r;
    logic medium_r;
    logic psc_clear;
    logic sub_edge;
    logic wake;
    pdmc_mode_t mode_r;

    // Wait count decode for the stabilization field
    function automatic logic [17:0] wait_states(input logic [2:0] code, input logic v2);
        logic [17:0] w;
        w = `PDMC_WAIT_8K;
        unique case (code)
            3'h0: w = `PDMC_WAIT_8K;
            3'h1: w = `PDMC_WAIT_16K;
            3'h2: w = v2 ? `PDMC_WAIT_32K : `PDMC_WAIT_1K;
            3'h3: w = v2 ? `PDMC_WAIT_64K : `PDMC_WAIT_2K;
            3'h4: w = v2 ? `PDMC_WAIT_128K : `PDMC_WAIT_4K;
            3'h5: w = `PDMC_WAIT_2;
            3'h6: w = `PDMC_WAIT_8;
            3'h7: w = `PDMC_WAIT_16;
        endcase
        return w;
    endfunction

    // Register writes; standby register resets to all ones
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            module_clock_stop_2_r <= `PDMC_MCS2_RST;
            timer_a_mode_register_r <= `PDMC_TMA_RST;
            system_control_1_r <= `PDMC_SYSCR_RST;
            irq_en_r <= {`PDMC_IEN_RST, `PDMC_IEN_RST};
        end else if (ce_i && wr_i) begin
            unique case (addr_i)
                `PDMC_OFS_MODULE_CLOCK_STOP_2: module_clock_stop_2_r <= wdata_i;
                `PDMC_OFS_TIMER_A_MODE: timer_a_mode_register_r <= wdata_i;
                `PDMC_OFS_SYSTEM_CONTROL_1: system_control_1_r <= wdata_i;
                `PDMC_OFS_IRQ_ENABLE_LO: irq_en_r[7:0] <= wdata_i;
                `PDMC_OFS_IRQ_ENABLE_HI: irq_en_r[15:8] <= wdata_i;
                default: ;
            endcase
        end
    end

    // Read data one cycle after strobe
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= 8'h00;
            if (rd_i) begin
                unique case (addr_i)
                    `PDMC_OFS_MODULE_CLOCK_STOP_2: rdata_o <= module_clock_stop_2_r;
                    `PDMC_OFS_TIMER_A_MODE: rdata_o <= timer_a_mode_register_r;
                    `PDMC_OFS_SYSTEM_CONTROL_1: rdata_o <= system_control_1_r;
                    `PDMC_OFS_POWER_MODE: rdata_o <= {2'h0, mode_r};
                    `PDMC_OFS_IRQ_ENABLE_LO: rdata_o <= irq_en_r[7:0];
                    `PDMC_OFS_IRQ_ENABLE_HI: rdata_o <= irq_en_r[15:8];
                    `PDMC_OFS_STATUS: rdata_o <= {5'h00, wait_code_bad_o, medium_r, cpu_run_o};
                    `PDMC_OFS_PRESCALER: rdata_o <= {3'h0, subclock_prescaler_r};
                    default: rdata_o <= 8'h00;
                endcase
            end
        end
    end

    // Subclock pin: three stages, a level change counts once stages two and three agree
    // Filtered level resets low like the idle pin, so no false edge follows reset
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sub_sync_r <= 3'h0;
            sub_lvl_r <= 1'b0;
        end else if (ce_i) begin
            sub_sync_r <= {sub_sync_r[1:0], subclock_osc_in_i};
            if (sub_sync_r[1] == sub_sync_r[2]) begin
                sub_lvl_r <= sub_sync_r[2];
            end
        end
    end
    // One-cycle rising edge of the filtered subclock level
    assign sub_edge = sub_sync_r[1] & sub_sync_r[2] & ~sub_lvl_r;

    // Divide-by-four of the subclock, then 5-bit prescaler
    assign psc_clear = ce_i && wr_i && (addr_i == `PDMC_OFS_TIMER_A_MODE)
        && wdata_i[`PDMC_TMA_CLR_HI] && wdata_i[`PDMC_TMA_CLR_LO];
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sub_div_r <= 2'h0;
            subclock_prescaler_r <= 5'h00;
        end else if (ce_i) begin
            if (psc_clear) begin
                sub_div_r <= 2'h0;
                subclock_prescaler_r <= 5'h00;
            end else if (sub_edge) begin
                // Counts in every mode, independent of mode_r
                sub_div_r <= sub_div_r + 2'h1;
                if (sub_div_r == 2'h3) begin
                    subclock_prescaler_r <= subclock_prescaler_r + 5'h01;
                end
            end
        end
    end
    assign subclock_prescaler_o = subclock_prescaler_r;
    // Prescaler terminal count as timer A clock when selected
    assign timer_a_tick_o = timer_a_mode_register_r[`PDMC_TMA_SRC_W] && sub_edge
        && (sub_div_r == 2'h3) && (subclock_prescaler_r == 5'h1f) && !psc_clear;

    // Interrupt request synchronizer, two clock delay
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_s1_r <= 16'h0000;
            irq_s2_r <= 16'h0000;
        end else if (ce_i) begin
            irq_s1_r <= irq_req_i;
            irq_s2_r <= irq_s1_r;
        end
    end
    // Requests stay visible whatever the module standby state
    assign irq_pend_o = irq_s2_r;
    assign wake = |(irq_s2_r & irq_en_r) && !condition_code_i_mask_i;

    // Power mode sequencer
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_r <= PDMC_ACTIVE;
            wait_cnt_r <= 18'h00000;
            medium_r <= 1'b0;
            exception_start_o <= 1'b0;
        end else if (ce_i) begin
            exception_start_o <= 1'b0;
            unique case (mode_r)
                PDMC_ACTIVE: begin
                    medium_r <= system_control_1_r[`PDMC_SYSCR_MA_LSB +: 2] != 2'h0;
                    if (sleep_req_i) begin
                        mode_r <= PDMC_SLEEP;
                    end else if (standby_req_i) begin
                        mode_r <= PDMC_STANDBY;
                    end else if (watch_req_i) begin
                        mode_r <= PDMC_WATCH;
                    end
                end
                PDMC_SLEEP: begin
                    if (wake) begin
                        mode_r <= PDMC_ACTIVE;
                        exception_start_o <= 1'b1;
                    end
                end
                PDMC_STANDBY, PDMC_WATCH: begin
                    if (wake) begin
                        mode_r <= PDMC_WAIT;
                        wait_cnt_r <= wait_states(
                            system_control_1_r[`PDMC_SYSCR_STS_LSB +: 3], VARIANT_TWO);
                    end
                end
                PDMC_WAIT: begin
                    if (wait_cnt_r <= 18'h00001) begin
                        mode_r <= PDMC_ACTIVE;
                        exception_start_o <= 1'b1;
                    end
                    wait_cnt_r <= wait_cnt_r - 18'h00001;
                end
                default: mode_r <= PDMC_ACTIVE;
            endcase
        end
    end

    // Medium-speed clock divider: none, 2, 4 or 8 per select code
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt_r <= 3'h0;
        end else if (ce_i) begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end
    always_comb begin
        sys_clk_en_o = 1'b1;
        if (medium_r && (mode_r == PDMC_SLEEP || mode_r == PDMC_ACTIVE)) begin
            unique case (system_control_1_r[`PDMC_SYSCR_MA_LSB +: 2])
                2'h0: sys_clk_en_o = 1'b1;
                2'h1: sys_clk_en_o = div_cnt_r[0] == 1'b0;
                2'h2: sys_clk_en_o = div_cnt_r[1:0] == 2'h0;
                2'h3: sys_clk_en_o = div_cnt_r == 3'h0;
            endcase
        end
    end

    // Module standby enables; voltage detector bit only in second variant
    assign module_run_o = {module_clock_stop_2_r[`PDMC_LVD_BIT] | ~VARIANT_TWO, 2'h3,
        module_clock_stop_2_r[4:0]};
    assign medium_speed_o = medium_r;
    assign cpu_run_o = (mode_r == PDMC_ACTIVE);
    assign cpu_reset_o = ~nrst_i;
    assign wait_code_bad_o = !ext_clock_i
        && system_control_1_r[`PDMC_SYSCR_STS_LSB +: 3] == 3'h5;

    // Assertions
    // Sleep with an unmasked, enabled request on an enabled clock
    sequence s_wake_in_sleep;
        ce_i && mode_r == PDMC_SLEEP && wake;
    endsequence
    // Standby or watch with a wake request on an enabled clock
    sequence s_wake_in_standby;
        ce_i && (mode_r == PDMC_STANDBY || mode_r == PDMC_WATCH) && wake;
    endsequence
    // Sleep request taken while the CPU runs
    sequence s_sleep_entry;
        ce_i && mode_r == PDMC_ACTIVE && sleep_req_i;
    endsequence
    a_sleep_wake_exit: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_wake_in_sleep |=> mode_r == PDMC_ACTIVE && exception_start_o)
        else $error("sleep not left on wake");
    a_sleep_mask_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        mode_r == PDMC_SLEEP && condition_code_i_mask_i |=> mode_r == PDMC_SLEEP)
        else $error("masked request woke device");
    a_sleep_idle_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_r == PDMC_SLEEP && !wake |=> mode_r == PDMC_SLEEP)
        else $error("sleep left without wake");
    a_sleep_entry_taken: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_sleep_entry |=> mode_r == PDMC_SLEEP)
        else $error("sleep request not taken");
    a_exc_one_pulse: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && exception_start_o |=> !exception_start_o)
        else $error("exception pulse too long");
    a_psc_clear_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        psc_clear |=> subclock_prescaler_r == 5'h00)
        else $error("prescaler not cleared");
    a_psc_step_one: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && !psc_clear && sub_edge && sub_div_r == 2'h3
        |=> subclock_prescaler_r == $past(subclock_prescaler_r) + 5'h01)
        else $error("prescaler step wrong");
    a_sub_edge_once: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && sub_edge |=> !sub_edge)
        else $error("subclock edge counted twice");
    a_psc_all_modes: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && !psc_clear && !sub_edge |=> $stable(subclock_prescaler_r))
        else $error("prescaler moved without subclock edge");
    a_tick_wraps_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && timer_a_tick_o |=> subclock_prescaler_r == 5'h00)
        else $error("timer a tick without wrap");
    a_irq_sync_two: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i ##1 ce_i |-> irq_s2_r == $past(irq_req_i, 2))
        else $error("request sync delay wrong");
    a_wait_entry: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        s_wake_in_standby |=> mode_r == PDMC_WAIT && !cpu_run_o)
        else $error("standby wake did not start wait");
    a_wait_cpu_held: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        mode_r == PDMC_WAIT |-> !cpu_run_o)
        else $error("cpu ran during wait");
    a_wait_short_end: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_r == PDMC_WAIT && wait_cnt_r == 18'h00002 ##1 ce_i
        |=> mode_r == PDMC_ACTIVE)
        else $error("wait did not end on count");
    a_medium_off: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_r == PDMC_ACTIVE && system_control_1_r[`PDMC_SYSCR_MA_LSB +: 2] == 2'h0
        |=> !medium_r)
        else $error("full speed not latched");
    a_medium_on: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && mode_r == PDMC_ACTIVE && system_control_1_r[`PDMC_SYSCR_MA_LSB +: 2] != 2'h0
        |=> medium_r)
        else $error("medium speed not latched");
    a_ce_low_freeze: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !ce_i |=> $stable(subclock_prescaler_r) && $stable(mode_r))
        else $error("state moved with clock enable low");
    a_rdata_idle_zero: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data stood past its cycle");
    a_lvd_no_function: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        !VARIANT_TWO |-> module_run_o[7])
        else $error("voltage detector bit active");
    a_standby_map: assert property (@(posedge mclk_i) disable iff (!nrst_i)
        module_run_o[4:0] == module_clock_stop_2_r[4:0])
        else $error("standby bit mapping wrong");

endmodule

/* pkg/pdmc_defines.svh */
// Purpose: Offsets, field positions, reset values and wait counts of the power-down control block
// Assumes: 8-bit register port, 100 MHz system clock
// Notes: Definitions only
`ifndef PDMC_DEFINES_SVH
`define PDMC_DEFINES_SVH

// Register offsets
`define PDMC_OFS_MODULE_CLOCK_STOP_2 4'h0
`define PDMC_OFS_TIMER_A_MODE 4'h1
`define PDMC_OFS_SYSTEM_CONTROL_1 4'h2
`define PDMC_OFS_POWER_MODE 4'h3
`define PDMC_OFS_IRQ_ENABLE_LO 4'h4
`define PDMC_OFS_IRQ_ENABLE_HI 4'h5
`define PDMC_OFS_STATUS 4'h6
`define PDMC_OFS_PRESCALER 4'h7

// Field positions
`define PDMC_TMA_CLR_HI 3
`define PDMC_TMA_CLR_LO 2
`define PDMC_TMA_SRC_W 7
`define PDMC_SYSCR_STS_LSB 4
`define PDMC_SYSCR_MA_LSB 0
`define PDMC_LVD_BIT 7

// Reset values
`define PDMC_MCS2_RST 8'hff
`define PDMC_TMA_RST 8'h00
`define PDMC_SYSCR_RST 8'h00
`define PDMC_IEN_RST 8'h00

// Wait counts in system-clock states
`define PDMC_WAIT_8K 18'h02000
`define PDMC_WAIT_16K 18'h04000
`define PDMC_WAIT_1K 18'h00400
`define PDMC_WAIT_2K 18'h00800
`define PDMC_WAIT_4K 18'h01000
`define PDMC_WAIT_2 18'h00002
`define PDMC_WAIT_8 18'h00008
`define PDMC_WAIT_16 18'h00010
`define PDMC_WAIT_32K 18'h08000
`define PDMC_WAIT_64K 18'h10000
`define PDMC_WAIT_128K 18'h20000
`define PDMC_SYNC_MAX 2

`endif

/* pkg/pdmc_pkg.sv */
// Purpose: Types of the power-down control block
// Assumes: Constants live in pdmc_defines.svh
// Notes: One-hot mode codes
package pdmc_pkg;
    typedef enum logic [5:0] {
        PDMC_ACTIVE = 6'h01,
        PDMC_SLEEP = 6'h02,
        PDMC_STANDBY = 6'h04,
        PDMC_WATCH = 6'h08,
        PDMC_WAIT = 6'h10,
        PDMC_SUB = 6'h20
    } pdmc_mode_t;
endpackage

/* testbench/pdmc_partner.sv */
// Purpose: Oscillator and interrupt-source model beside the power-down block
// Assumes: Subclock period is eight system clocks
// Notes: Subclock stands still while osc_run_i is low
`timescale 1ns/1ps
module pdmc_partner (
    // Clock and controls
    input wire logic mclk_i,
    input wire logic osc_run_i,
    input wire logic [15:0] irq_set_i,
    // Lines toward the block
    output logic subclock_o,
    output logic [15:0] irq_o
);
    logic [1:0] div_r;
    initial begin
        div_r = 2'h0;
        subclock_o = 1'b0;
        irq_o = 16'h0000;
    end
    // Subclock toggles every fourth system clock while running
    always @(posedge mclk_i) begin
        if (osc_run_i) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                subclock_o <= ~subclock_o;
            end
        end
    end
    // Request levels follow the source settings one edge late
    always @(posedge mclk_i) begin
        irq_o <= irq_set_i;
    end
endmodule

/* testbench/pdmc_top_tb.sv */
// Purpose: Self-checking bench of the power-down control block
// Assumes: Variant one, 100 MHz clock
// Notes: Short wait codes only, long ones would dominate run time
`timescale 1ns/1ps
module pdmc_top_tb;
    import pdmc_pkg::*;
    logic mclk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, module_run_o, d;
    logic mask_i = 1'b1, sleep_i = 1'b0, stby_i = 1'b0, watch_i = 1'b0, ext_i = 1'b1;
    logic osc_run = 1'b0, sub_w, cpu_run_o, cpu_reset_o, exc_o, tick_o, bad_o, med_o, clken_o;
    logic [15:0] irq_set = 16'h0000, irq_w, irq_pend_o;
    logic [4:0] presc_o;
    int n_errors = 0, checks_done = 0, cnt;
    // Free-running system clock
    always #5 mclk_i = ~mclk_i;
    pdmc_partner part_u (.mclk_i(mclk_i), .osc_run_i(osc_run), .irq_set_i(irq_set),
        .subclock_o(sub_w), .irq_o(irq_w));
    pdmc_top dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .subclock_osc_in_i(sub_w), .irq_req_i(irq_w), .condition_code_i_mask_i(mask_i),
        .sleep_req_i(sleep_i), .standby_req_i(stby_i), .watch_req_i(watch_i),
        .ext_clock_i(ext_i), .cpu_run_o(cpu_run_o), .cpu_reset_o(cpu_reset_o),
        .exception_start_o(exc_o), .medium_speed_o(med_o), .sys_clk_en_o(clken_o),
        .timer_a_tick_o(tick_o), .subclock_prescaler_o(presc_o),
        .module_run_o(module_run_o), .irq_pend_o(irq_pend_o), .wait_code_bad_o(bad_o));
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // One-cycle register write and read
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= v;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic pulse_sleep();
        @(posedge mclk_i);
        sleep_i <= 1'b1;
        @(posedge mclk_i);
        sleep_i <= 1'b0;
    endtask
    task automatic t_regs();
        rd(4'h0, d); chk("standby reset", d, 8'hff);
        rd(4'h3, d); chk("mode reset", d, 8'h01);
        rd(4'h7, d); chk("prescaler reset", d, 8'h00);
        wr(4'hf, 8'h5a);
        rd(4'h8, d); chk("unmapped read", d, 8'h00);
        wr(4'h0, 8'h15);
        rd(4'h0, d); chk("standby readback", d, 8'h15);
        chk("module run", module_run_o, 8'hf5);
        wr(4'h0, 8'hff);
        tick(1); chk("module run all", module_run_o, 8'hff);
        $display("done regs");
    endtask
    task automatic t_wake();
        wr(4'h4, 8'h01);
        pulse_sleep();
        irq_set <= 16'h0002;
        tick(6); rd(4'h3, d); chk("disabled irq", d, 8'h02);
        irq_set <= 16'h0003;
        tick(6); rd(4'h3, d); chk("masked irq", d, 8'h02);
        wr(4'h0, 8'h00);
        tick(1); chk("pending kept", irq_pend_o, 16'h0003);
        wr(4'h0, 8'hff);
        mask_i <= 1'b0;
        cnt = 0;
        while (exc_o !== 1'b1 && cnt < 10) begin
            tick(1);
            cnt++;
        end
        chk("wake delay ok", cnt <= 4, 1);
        chk("cpu runs", cpu_run_o, 1'b1);
        tick(1); chk("exception pulse ends", exc_o, 1'b0);
        rd(4'h3, d); chk("mode active", d, 8'h01);
        irq_set <= 16'h0000;
        mask_i <= 1'b1;
        tick(4);
        $display("done wake");
    endtask
    task automatic t_standby();
        int w[3] = '{2, 8, 16};
        for (int i = 0; i < 3; i++) begin
            wr(4'h2, {1'b0, 3'(5 + i), 4'h0});
            @(posedge mclk_i);
            if (i == 2) watch_i <= 1'b1;
            else stby_i <= 1'b1;
            @(posedge mclk_i);
            watch_i <= 1'b0;
            stby_i <= 1'b0;
            rd(4'h3, d); chk("low-power mode", d, (i == 2) ? 8'h08 : 8'h04);
            mask_i <= 1'b0;
            irq_set <= 16'h0001;
            cnt = 0;
            while (cpu_run_o !== 1'b1 && cnt < 100) begin
                tick(1);
                cnt++;
            end
            chk("wait length", cnt >= w[i] && cnt <= w[i] + 6, 1);
            irq_set <= 16'h0000;
            mask_i <= 1'b1;
            tick(4);
        end
        $display("done standby");
    endtask
    task automatic t_bad();
        ext_i <= 1'b0;
        wr(4'h2, 8'h50);
        tick(1); chk("bad code flag", bad_o, 1'b1);
        ext_i <= 1'b1;
        tick(1); chk("bad code clear", bad_o, 1'b0);
        $display("done badcode");
    endtask
    // Medium speed: divide-by-four code, enable rate in active and in sleep
    task automatic t_medium();
        wr(4'h2, 8'h02);
        tick(2); chk("medium select", med_o, 1'b1);
        cnt = 0;
        repeat (16) begin
            tick(1);
            if (clken_o === 1'b1) cnt++;
        end
        chk("active quarter rate", cnt, 4);
        pulse_sleep();
        cnt = 0;
        repeat (16) begin
            tick(1);
            if (clken_o === 1'b1) cnt++;
        end
        chk("sleep quarter rate", cnt, 4);
        $display("done medium");
    endtask
    task automatic t_presc();
        pulse_sleep();
        wr(4'h1, 8'h0c);
        tick(2); chk("cleared", presc_o, 5'h00);
        osc_run <= 1'b1;
        tick(64);
        osc_run <= 1'b0;
        tick(8); chk("count in sleep", presc_o, 5'h02);
        wr(4'h1, 8'h8c);
        cnt = 0;
        osc_run <= 1'b1;
        for (int i = 0; i < 1040; i++) begin
            if (i == 1024) osc_run <= 1'b0;
            tick(1);
            if (tick_o === 1'b1) cnt++;
        end
        chk("timer a ticks", cnt, 1);
        chk("wrapped", presc_o, 5'h00);
        $display("done prescaler");
    endtask
    task automatic t_reset();
        rd(4'h3, d); chk("still asleep", d, 8'h02);
        nrst_i <= 1'b0;
        tick(1); chk("cpu reset", cpu_reset_o, 1'b1);
        tick(2);
        nrst_i <= 1'b1;
        tick(1);
        rd(4'h3, d); chk("sleep ended", d, 8'h01);
        rd(4'h7, d); chk("prescaler cleared", d, 8'h00);
        $display("done reset");
    endtask
    // End the run with the verdict
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        t_regs();
        t_wake();
        t_standby();
        t_bad();
        t_medium();
        t_presc();
        t_reset();
        conclude();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule
